// ---- rtl/dlc_top.sv ----
`timescale 1ns/1ps
`include "dlc_consts.svh"

// Summary of operation
// - ac select: 0 real 600, 1 complex
// - ringer bit enables synthesized maximum impedance
// - attenuate tx 1.7 dB Japan, 4 dB low-voltage
// - force bits act only in FCC mode
// - on-hook speed ramps loop current down slowly
// - detection runs only while enable is set
// - tones under 1.1 V peak never flagged
// - overload flag set above 1.1 V peak
// - supply dip sets detect, selects 800 ohm
// - flags stay set until written zero
// - live overload follows condition, never latches
// - two-bit field picks one of four modes
module dlc_top
    import dlc_pkg::*;
#(
    parameter int RETURN_CYCLES = int'(`DLC_CLK_HZ / 32'h0000_03E8 * `DLC_RETURN_MS),
    parameter int RETURN_W      = 25,
    parameter int STEP_W        = 14
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ac_term_select,
    input  wire logic        i_ringer_imp_enable,
    input  wire logic [1:0]  i_dc_term_mode,
    input  wire logic        i_force_japan_term,
    input  wire logic        i_force_lowvolt_term,
    input  wire logic        i_dial_headroom,
    input  wire logic [1:0]  i_onhook_speed,
    input  wire logic        i_offhook,
    input  wire logic        i_billing_tone_enable,
    input  wire logic [11:0] i_line_peak_mv,
    input  wire logic        i_supply_depressed,
    input  wire logic        i_flag_write,
    input  wire logic        i_rx_overload_wdata,
    input  wire logic        i_billing_tone_wdata,
    output logic             o_ac_complex_term,
    output logic             o_ringer_synth_enable,
    output logic [1:0]       o_dc_term_active,
    output logic             o_dc_800ohm,
    output logic [5:0]       o_tx_atten_tenth_db,
    output logic             o_dial_headroom_active,
    output logic [7:0]       o_loop_current_level,
    output logic             o_rx_overload_live,
    output logic             o_rx_overload_sticky,
    output logic             o_billing_tone_detected
);

    localparam int STEP1_CYCLES = int'(`DLC_CLK_MHZ * `DLC_OHS_STEP1_US);
    localparam int STEP2_CYCLES = int'(`DLC_CLK_MHZ * `DLC_OHS_STEP2_US);
    localparam int STEP3_CYCLES = int'(`DLC_CLK_MHZ * `DLC_OHS_STEP3_US);

    // reset released through two flops; asserted asynchronously
    logic rst_sync1_reg;
    logic rst_n;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync1_reg <= 1'b0;
            rst_n         <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n         <= rst_sync1_reg;
        end
    end

    dlc_top_state_t   st_reg;
    dlc_top_state_t   st_next;
    dlc_dct_t         mode;
    logic             over_thresh;
    logic             rov_set;
    logic             btd_set;
    logic             ret_start;
    logic             ret_done;
    logic             ret_busy;
    logic             step_start;
    logic             step_done;
    logic             step_busy;
    logic [STEP_W-1:0] step_count;

    assign mode        = dlc_dct_t'(i_dc_term_mode);
    // anything at or under 1.1 V peak is treated as removed by the receive filter
    assign over_thresh = i_line_peak_mv > `DLC_OVL_THRESH_MV;
    assign rov_set     = i_billing_tone_enable && over_thresh;
    assign btd_set     = i_billing_tone_enable && i_supply_depressed;

    dlc_flag u_rov_flag (
        .i_clk   (i_sys_clk),
        .i_rst_n (rst_n),
        .i_set   (rov_set),
        .i_wr    (i_flag_write),
        .i_wdata (i_rx_overload_wdata),
        .o_flag  (o_rx_overload_sticky)
    );

    dlc_flag u_btd_flag (
        .i_clk   (i_sys_clk),
        .i_rst_n (rst_n),
        .i_set   (btd_set),
        .i_wr    (i_flag_write),
        .i_wdata (i_billing_tone_wdata),
        .o_flag  (o_billing_tone_detected)
    );

    // 800 ohm hold: released about one second after enable is cleared
    assign ret_start = (st_reg.bt_state == DLC_BT_HOLD) && !i_billing_tone_enable;

    dlc_timer #(
        .W (RETURN_W)
    ) u_return_timer (
        .i_clk   (i_sys_clk),
        .i_rst_n (rst_n),
        .i_start (ret_start),
        .i_abort (1'b0),
        .i_count (RETURN_W'(RETURN_CYCLES)),
        .o_busy  (ret_busy),
        .o_done  (ret_done)
    );

    // step period picked by on-hook speed; slower codes trade pulse edge time for a smaller spike
    always_comb begin
        unique case (i_onhook_speed)
            2'h1:    step_count = STEP_W'(STEP1_CYCLES);
            2'h2:    step_count = STEP_W'(STEP2_CYCLES);
            2'h3:    step_count = STEP_W'(STEP3_CYCLES);
            default: step_count = STEP_W'(1);
        endcase
    end

    assign step_start = !i_offhook && (i_onhook_speed != `DLC_OHS_ABRUPT)
                        && (st_reg.loop_level != `DLC_LOOP_ZERO);

    dlc_timer #(
        .W (STEP_W)
    ) u_step_timer (
        .i_clk   (i_sys_clk),
        .i_rst_n (rst_n),
        .i_start (step_start),
        .i_abort (i_offhook),
        .i_count (step_count),
        .o_busy  (step_busy),
        .o_done  (step_done)
    );

    always_comb begin
        st_next = st_reg;

        st_next.ac_complex   = i_ac_term_select;
        st_next.ringer_synth = i_ringer_imp_enable;
        st_next.ovl_live     = rov_set;

        // force bits only matter in FCC mode
        st_next.dc_eff = mode;
        if (mode == DLC_DCT_FCC) begin
            if (i_force_japan_term) begin
                st_next.dc_eff = DLC_DCT_JAPAN;
            end else if (i_force_lowvolt_term) begin
                st_next.dc_eff = DLC_DCT_LOWVOLT;
            end
        end

        // attenuation follows the programmed code, so forced FCC dials at full level
        unique case (mode)
            DLC_DCT_JAPAN:   st_next.atten = `DLC_ATTEN_JAPAN;
            DLC_DCT_LOWVOLT: st_next.atten = `DLC_ATTEN_LOWVOLT;
            DLC_DCT_FCC,
            DLC_DCT_CTR21:   st_next.atten = `DLC_ATTEN_NONE;
        endcase

        // headroom boost only honoured in CTR21; line voltage gating is left to the host
        st_next.headroom = i_dial_headroom && (mode == DLC_DCT_CTR21);

        unique case (st_reg.bt_state)
            DLC_BT_IDLE: begin
                if (btd_set) begin
                    st_next.bt_state = DLC_BT_HOLD;
                end
            end
            DLC_BT_HOLD: begin
                if (!i_billing_tone_enable) begin
                    st_next.bt_state = DLC_BT_RETURN;
                end
            end
            DLC_BT_RETURN: begin
                if (ret_done) begin
                    st_next.bt_state = DLC_BT_IDLE;
                end
            end
            default: st_next.bt_state = DLC_BT_IDLE;
        endcase

        if (i_offhook) begin
            st_next.loop_level = `DLC_LOOP_FULL;
        end else if (i_onhook_speed == `DLC_OHS_ABRUPT) begin
            st_next.loop_level = `DLC_LOOP_ZERO;
        end else if (step_done && st_reg.loop_level != `DLC_LOOP_ZERO) begin
            st_next.loop_level = st_reg.loop_level - `DLC_LOOP_STEP;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg          <= '0;
            st_reg.bt_state <= DLC_BT_IDLE;
            st_reg.dc_eff   <= DLC_DCT_FCC;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_ac_complex_term      = st_reg.ac_complex;
    assign o_ringer_synth_enable  = st_reg.ringer_synth;
    assign o_dc_term_active       = st_reg.dc_eff;
    // bt_state leaves idle in the same edge that sets the detect flag
    assign o_dc_800ohm            = st_reg.bt_state != DLC_BT_IDLE;
    assign o_tx_atten_tenth_db    = st_reg.atten;
    assign o_dial_headroom_active = st_reg.headroom;
    assign o_loop_current_level   = st_reg.loop_level;
    assign o_rx_overload_live     = st_reg.ovl_live;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    property p_ac_term;
        ##1 o_ac_complex_term == $past(i_ac_term_select);
    endproperty
    a_ac_term: assert property (p_ac_term) else $error("ac termination does not follow select");

    property p_ringer;
        ##1 o_ringer_synth_enable == $past(i_ringer_imp_enable);
    endproperty
    a_ringer: assert property (p_ringer) else $error("ringer synthesis not enabled");

    property p_atten;
        mode == DLC_DCT_JAPAN |=> o_tx_atten_tenth_db == `DLC_ATTEN_JAPAN;
    endproperty
    a_atten: assert property (p_atten) else $error("japan attenuation wrong");

    property p_atten_lowvolt;
        mode == DLC_DCT_LOWVOLT |=> o_tx_atten_tenth_db == `DLC_ATTEN_LOWVOLT;
    endproperty
    a_atten_lowvolt: assert property (p_atten_lowvolt) else $error("low-voltage attenuation wrong");

    property p_force_japan;
        mode == DLC_DCT_FCC && i_force_japan_term |=> o_dc_term_active == DLC_DCT_JAPAN;
    endproperty
    a_force_japan: assert property (p_force_japan) else $error("forced japan termination not applied");

    property p_force_lowvolt;
        mode == DLC_DCT_FCC && !i_force_japan_term && i_force_lowvolt_term
            |=> o_dc_term_active == DLC_DCT_LOWVOLT;
    endproperty
    a_force_lowvolt: assert property (p_force_lowvolt) else $error("forced low-voltage termination not applied");

    property p_force_ignored;
        mode != DLC_DCT_FCC |=> o_dc_term_active == $past(i_dc_term_mode);
    endproperty
    a_force_ignored: assert property (p_force_ignored) else $error("force bit acted outside FCC");

    property p_fcc_plain;
        mode == DLC_DCT_FCC && !i_force_japan_term && !i_force_lowvolt_term |=> o_dc_term_active == DLC_DCT_FCC;
    endproperty
    a_fcc_plain: assert property (p_fcc_plain) else $error("FCC mode not selected");

    property p_ramp;
        !i_offhook && i_onhook_speed != `DLC_OHS_ABRUPT && o_loop_current_level != `DLC_LOOP_ZERO
            |=> o_loop_current_level == $past(o_loop_current_level)
                || o_loop_current_level == $past(o_loop_current_level) - `DLC_LOOP_STEP;
    endproperty
    a_ramp: assert property (p_ramp) else $error("loop current not ramped gradually");

    property p_disabled_quiet;
        !i_billing_tone_enable |=> !o_rx_overload_live;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("overload reported while disabled");

    property p_small_tone;
        i_billing_tone_enable && i_line_peak_mv <= `DLC_OVL_THRESH_MV |=> !o_rx_overload_live;
    endproperty
    a_small_tone: assert property (p_small_tone) else $error("sub-threshold tone flagged");

    property p_overload_set;
        i_billing_tone_enable && i_line_peak_mv > `DLC_OVL_THRESH_MV |=> o_rx_overload_sticky && o_rx_overload_live;
    endproperty
    a_overload_set: assert property (p_overload_set) else $error("overload not flagged");

    property p_btd_800;
        $rose(o_billing_tone_detected) |-> o_dc_800ohm;
    endproperty
    a_btd_800: assert property (p_btd_800) else $error("800 ohm not applied on detection");

    property p_live_follows;
        ##1 o_rx_overload_live == $past(rov_set);
    endproperty
    a_live_follows: assert property (p_live_follows) else $error("live overload latched");

endmodule : dlc_top

// ---- rtl/dlc_consts.svh ----
`ifndef DLC_CONSTS_SVH
`define DLC_CONSTS_SVH

// clock rate and derived time bases
`define DLC_CLK_HZ          32'h017D_7840
`define DLC_CLK_MHZ         32'h0000_0019
// overload threshold, line peak in millivolts (1.1 V)
`define DLC_OVL_THRESH_MV   12'h44C
// transmit attenuation, tenths of a dB
`define DLC_ATTEN_NONE      6'h00
`define DLC_ATTEN_JAPAN     6'h11
`define DLC_ATTEN_LOWVOLT   6'h28
// termination return time after billing tone detection is disabled, ms
`define DLC_RETURN_MS       32'h0000_03E8
// on-hook ramp step times, microseconds per loop current step
`define DLC_OHS_STEP1_US    32'h0000_0064
`define DLC_OHS_STEP2_US    32'h0000_00C8
`define DLC_OHS_STEP3_US    32'h0000_0190
// on-hook speed code for an abrupt cut
`define DLC_OHS_ABRUPT      2'h0
// loop current levels
`define DLC_LOOP_FULL       8'hFF
`define DLC_LOOP_ZERO       8'h00
`define DLC_LOOP_STEP       8'h01

`endif

// ---- rtl/dlc_pkg.sv ----
package dlc_pkg;

    typedef enum logic [1:0] {
        DLC_DCT_LOWVOLT,
        DLC_DCT_JAPAN,
        DLC_DCT_FCC,
        DLC_DCT_CTR21
    } dlc_dct_t;

    typedef enum logic [1:0] {
        DLC_BT_IDLE,
        DLC_BT_HOLD,
        DLC_BT_RETURN
    } dlc_bt_state_t;

    typedef struct packed {
        dlc_bt_state_t bt_state;
        logic          ovl_live;
        logic          ac_complex;
        logic          ringer_synth;
        dlc_dct_t      dc_eff;
        logic [5:0]    atten;
        logic          headroom;
        logic [7:0]    loop_level;
    } dlc_top_state_t;

endpackage : dlc_pkg

// ---- rtl/dlc_flag.sv ----
`timescale 1ns/1ps
`include "dlc_consts.svh"

// sticky status flag: hardware sets, software clears by writing zero
module dlc_flag
    import dlc_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_set,
    input  wire logic i_wr,
    input  wire logic i_wdata,
    output logic      o_flag
);

    typedef struct packed {
        logic flag;
    } dlc_flag_state_t;

    dlc_flag_state_t st_reg;
    dlc_flag_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (i_wr && !i_wdata) begin
            st_next.flag = 1'b0;
        end
        // set after clear so a coincident event is kept
        if (i_set) begin
            st_next.flag = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_flag = st_reg.flag;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_flag_sticky;
        o_flag && !(i_wr && !i_wdata) |=> o_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("sticky flag dropped without a zero write");

    property p_set_wins;
        i_set |=> o_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost against a clear");

    property p_zero_clears;
        !i_set && i_wr && !i_wdata |=> !o_flag;
    endproperty
    a_zero_clears: assert property (p_zero_clears) else $error("zero write did not clear flag");

endmodule : dlc_flag

// ---- rtl/dlc_timer.sv ----
`timescale 1ns/1ps
`include "dlc_consts.svh"

// one-shot down counter; o_done pulses one cycle when the count expires
module dlc_timer
    import dlc_pkg::*;
#(
    parameter int W = 25
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_start,
    input  wire logic         i_abort,
    input  wire logic [W-1:0] i_count,
    output logic              o_busy,
    output logic              o_done
);

    typedef struct packed {
        logic         busy;
        logic         done;
        logic [W-1:0] cnt;
    } dlc_timer_state_t;

    dlc_timer_state_t st_reg;
    dlc_timer_state_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (i_abort) begin
            st_next.busy = 1'b0;
        end else if (i_start && !st_reg.busy) begin
            st_next.busy = 1'b1;
            st_next.cnt  = i_count;
        end else if (st_reg.busy) begin
            if (st_reg.cnt <= W'(1)) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_busy = st_reg.busy;
    assign o_done = st_reg.done;

endmodule : dlc_timer

// ---- tb/dlc_line_model.sv ----
`timescale 1ns/1ps

// telephone line as seen through the line-side device
module dlc_line_model
    import dlc_pkg::*;
#(
    parameter logic [11:0] DIP_MV = 12'h7D0
) (
    input  wire logic        i_tone_on,
    input  wire logic [11:0] i_tone_mv,
    output logic [11:0]      o_peak_mv,
    output logic             o_supply_dip
);
    // silent line reads zero peak, not the last tone level
    assign o_peak_mv    = i_tone_on ? i_tone_mv : 12'h000;
    // only a tone above the supply budget starves the line-side supply
    assign o_supply_dip = i_tone_on & (i_tone_mv > DIP_MV);
endmodule : dlc_line_model

// ---- tb/dlc_top_tb.sv ----
`timescale 1ns/1ps

module dlc_top_tb
    import dlc_pkg::*;
;
    localparam int RET = 20;
    logic        clk    = 1'b0;
    logic        nrst   = 1'b0;
    logic        ac     = 1'b0;
    logic        rz     = 1'b0;
    logic [1:0]  mode   = 2'h2;
    logic        fj     = 1'b0;
    logic        flv    = 1'b0;
    logic        hr     = 1'b0;
    logic [1:0]  onhook_speed    = 2'h0;
    logic        hook   = 1'b0;
    logic        billing_tone_enable    = 1'b0;
    logic        tn_on  = 1'b0;
    logic [11:0] tn_mv  = 12'h000;
    logic        fw     = 1'b0;
    logic        wd     = 1'b1;
    logic        wdb    = 1'b1;
    logic [11:0] peak;
    logic        dip;
    logic        o_ac, o_rz, o_800, o_hr, o_live, o_rov, o_btd;
    logic [1:0]  o_dct;
    logic [5:0]  o_att;
    logic [7:0]  o_loop;
    logic [1:0]  em;
    int          err_total = 0;
    int          tests_run = 0;
    int          n;

    always #20 clk = ~clk;

    dlc_line_model dlc_line_model_inst (
        .i_tone_on(tn_on), .i_tone_mv(tn_mv), .o_peak_mv(peak), .o_supply_dip(dip));

    dlc_top #(.RETURN_CYCLES(RET)) dlc_top_inst (
        .i_sys_clk(clk), .i_nrst(nrst), .i_ac_term_select(ac), .i_ringer_imp_enable(rz),
        .i_dc_term_mode(mode), .i_force_japan_term(fj), .i_force_lowvolt_term(flv),
        .i_dial_headroom(hr), .i_onhook_speed(onhook_speed), .i_offhook(hook),
        .i_billing_tone_enable(billing_tone_enable), .i_line_peak_mv(peak), .i_supply_depressed(dip),
        .i_flag_write(fw), .i_rx_overload_wdata(wd), .i_billing_tone_wdata(wdb),
        .o_ac_complex_term(o_ac), .o_ringer_synth_enable(o_rz), .o_dc_term_active(o_dct),
        .o_dc_800ohm(o_800), .o_tx_atten_tenth_db(o_att), .o_dial_headroom_active(o_hr),
        .o_loop_current_level(o_loop), .o_rx_overload_live(o_live),
        .o_rx_overload_sticky(o_rov), .o_billing_tone_detected(o_btd));

    task print_verdict;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick

    // one strobe, separate data for each sticky flag
    task wr(input logic d, input logic db);
        @(posedge clk);
        fw  <= 1'b1;
        wd  <= d;
        wdb <= db;
        @(posedge clk);
        fw <= 1'b0;
        #1;
    endtask : wr

    task tone(input logic [11:0] mv);
        @(posedge clk);
        tn_on <= (mv != 12'h000);
        tn_mv <= mv;
        tick(1);
    endtask : tone

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("BAD t=%0t run hung", $time);
        print_verdict;
    end

    initial begin
        tick(19);
        chk(8'(o_dct), 8'(DLC_DCT_FCC));
        chk(8'(o_att), 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        tick(3);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ac <= k[0];
            rz <= ~k[0];
            tick(1);
            chk(8'(o_ac), 8'(k));
            chk(8'(o_rz), 8'(1 - k));
        end
        // headroom held high throughout; only the current-limited mode lets it through
        for (int m = 0; m < 4; m++) begin
            for (int f = 0; f < 4; f++) begin
                @(posedge clk);
                mode <= 2'(m);
                fj   <= f[1];
                flv  <= f[0];
                hr   <= 1'b1;
                tick(1);
                em = (m != 2) ? 2'(m) : f[1] ? 2'h1 : f[0] ? 2'h0 : 2'h2;
                chk(8'(o_dct), 8'(em));
                chk(8'(o_att), m == 1 ? 8'h11 : m == 0 ? 8'h28 : 8'h00);
                chk(8'(o_hr), 8'(m == 3));
            end
        end
        // back to the japan code after forced dialing: attenuation returns, leftover force bits do nothing
        @(posedge clk);
        mode <= 2'h1;
        tick(1);
        chk(8'(o_att), 8'h11);
        chk(8'(o_dct), 8'h01);
        @(posedge clk);
        mode <= 2'h2;
        fj   <= 1'b0;
        flv  <= 1'b0;
        hr   <= 1'b0;
        tone(12'h9C4);
        tick(2);
        chk(8'({o_live, o_rov, o_btd, o_800}), 8'h00);
        tone(12'h000);
        @(posedge clk);
        billing_tone_enable <= 1'b1;
        tone(12'h44C);
        tick(1);
        chk(8'({o_live, o_rov, o_btd, o_800}), 8'h00);
        tone(12'h44D);
        chk(8'(o_live), 8'h01);
        chk(8'({o_rov, o_btd}), 8'h02);
        tone(12'h000);
        chk(8'(o_live), 8'h00);
        chk(8'(o_rov), 8'h01);
        wr(1'b1, 1'b1);
        chk(8'(o_rov), 8'h01);
        tone(12'h44D);
        wr(1'b0, 1'b0);
        chk(8'(o_rov), 8'h01);
        tone(12'h000);
        wr(1'b0, 1'b0);
        chk(8'(o_rov), 8'h00);
        tone(12'h9C4);
        chk(8'({o_rov, o_btd, o_800}), 8'h07);
        tone(12'h000);
        for (n = 0; n < 10 && o_live !== 1'b0; n++) tick(1);
        chk(8'(o_live), 8'h00);
        // clear one flag at a time so crossed data lines would show
        wr(1'b0, 1'b1);
        chk(8'({o_rov, o_btd, o_800}), 8'h03);
        wr(1'b1, 1'b0);
        chk(8'({o_rov, o_btd, o_800}), 8'h01);
        @(posedge clk);
        billing_tone_enable <= 1'b0;
        tick(RET / 2);
        chk(8'(o_800), 8'h01);
        for (n = 0; n < 3 * RET && o_800 !== 1'b0; n++) tick(1);
        chk(8'(o_800), 8'h00);
        @(posedge clk);
        billing_tone_enable <= 1'b1;
        tick(2);
        chk(8'({o_rov, o_btd, o_800}), 8'h00);
        // a second tone is caught again, so the host can count repeats
        tone(12'h9C4);
        chk(8'({o_rov, o_btd, o_800}), 8'h07);
        tone(12'h000);
        // abrupt hook toggles stand in for dial pulses at a shortened rate
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            hook <= 1'b1;
            tick(1);
            chk(o_loop, 8'hFF);
            @(posedge clk);
            hook <= 1'b0;
            tick(1);
            chk(o_loop, 8'h00);
        end
        @(posedge clk);
        hook <= 1'b1;
        onhook_speed  <= 2'h1;
        tick(1);
        @(posedge clk);
        hook <= 1'b0;
        // first step lands 2502 cycles after the hook drops (timer load, 2500-cycle count, level register); look on both sides
        tick(2490);
        chk(o_loop, 8'hFF);
        tick(20);
        chk(o_loop, 8'hFE);
        @(posedge clk);
        hook <= 1'b1;
        tick(1);
        chk(o_loop, 8'hFF);
        print_verdict;
    end
endmodule : dlc_top_tb
